// [design/pis_regs.svh]
// Timing constants and encodings for the power increase sequencer.
// Assumes a 125 MHz system clock; included by bare name.
`ifndef PIS_REGS_SVH
`define PIS_REGS_SVH

// System clock period in picoseconds
`define PIS_CLK_PERIOD_PS        32'h0000_1F40
// Wait between the Accept acknowledge and the supply change command, in microseconds
`define PIS_SETTLE_WAIT_US       32'h0000_0019
// Longest time the supply may take to report ready, in microseconds
`define PIS_SUPPLY_READY_US      32'h0000_01F4
// Cycle counts derived from the times above
`define PIS_SETTLE_WAIT_CYC      ((`PIS_SETTLE_WAIT_US * 32'h0000_03E8 * 32'h0000_03E8 + \
                                   `PIS_CLK_PERIOD_PS - 32'h0000_0001) / `PIS_CLK_PERIOD_PS)
`define PIS_SUPPLY_READY_CYC     ((`PIS_SUPPLY_READY_US * 32'h0000_03E8 * 32'h0000_03E8) / \
                                   `PIS_CLK_PERIOD_PS)
// Outgoing message codes
`define PIS_MSG_ACCEPT           4'h3
`define PIS_MSG_PS_RDY           4'h6

`endif

// [design/pis_pkg.sv]
// Types shared by the power increase sequencer.
// Assumes nothing of its surroundings.
package pis_pkg;
    typedef enum logic [2:0] {
        PIS_IDLE,
        PIS_SEND_ACCEPT,
        PIS_WAIT_ACK,
        PIS_SETTLE,
        PIS_SUPPLY_CHANGE,
        PIS_SEND_RDY,
        PIS_WAIT_RDY_ACK,
        PIS_FAULT
    } pis_state_t;
    typedef logic [3:0] pis_msg_t;
endpackage

// [design/pis_timer.sv]
// Down counter used for the settle wait and the supply ready limit.
// Assumes a load pulse from logic on the same clock.
`timescale 1ns/10ps
module pis_timer #(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input  wire logic             clk_sys_in,
    input  wire logic             srst_in,
    // Control
    input  wire logic             load_in,
    input  wire logic [WIDTH-1:0] count_in,
    input  wire logic             stop_in,
    // Status
    output logic                  expired_out
);
    logic [WIDTH-1:0] cnt_reg;
    logic [WIDTH-1:0] cnt_next;
    logic             run_reg;
    logic             run_next;
    logic             exp_reg;
    logic             exp_next;

    always_comb begin
        cnt_next = cnt_reg;
        run_next = run_reg;
        exp_next = 1'b0;
        if (load_in) begin
            cnt_next = count_in;
            run_next = 1'b1;
        end else if (stop_in) begin
            run_next = 1'b0;
        end else if (run_reg) begin
            if (cnt_reg <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                run_next = 1'b0;
                exp_next = 1'b1;
            end else begin
                cnt_next = cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
            exp_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            run_reg <= run_next;
            exp_reg <= exp_next;
        end
    end

    assign expired_out = exp_reg;
endmodule

// [design/pis_source_seq.sv]
// Source side sequencer for raising voltage and current after a sink request.
// Assumes the protocol layer and supply controller run on clk_sys_in.
`timescale 1ns/10ps
`include "pis_regs.svh"
module pis_source_seq #(
    parameter int unsigned SETTLE_CYC = `PIS_SETTLE_WAIT_CYC,
    parameter int unsigned READY_CYC  = `PIS_SUPPLY_READY_CYC
) (
    // Clock and reset
    input  wire logic              clk_sys_in,
    input  wire logic              srst_in,
    // Policy side
    input  wire logic              request_ok_in,
    output logic                   busy_out,
    output logic                   done_out,
    output logic                   fault_out,
    output logic                   supply_ready_out,
    // Protocol layer transmit
    output logic                   tx_valid_out,
    output pis_pkg::pis_msg_t      tx_msg_out,
    input  wire logic              tx_ready_in,
    input  wire logic              tx_goodcrc_in,
    input  wire logic              tx_fail_in,
    // Supply controller
    output logic                   supply_change_out,
    input  wire logic              supply_ready_in
);
    import pis_pkg::*;

    // ****************************************************************
    // Sequencer state
    // ****************************************************************
    pis_state_t state_reg;
    pis_state_t state_next;
    logic       done_reg;
    logic       done_next;
    logic       fault_reg;
    logic       fault_next;
    logic       rdy_reg;
    logic       rdy_next;
    logic       chg_reg;
    logic       chg_next;
    pis_msg_t   msg_reg;
    pis_msg_t   msg_next;
    logic       t_load;
    logic [31:0] t_count;
    logic       t_stop;
    logic       t_expired;

    pis_timer #(
        .WIDTH(32)
    ) u_timer (
        .clk_sys_in  (clk_sys_in),
        .srst_in     (srst_in),
        .load_in     (t_load),
        .count_in    (t_count),
        .stop_in     (t_stop),
        .expired_out (t_expired)
    );

    always_comb begin
        state_next = state_reg;
        done_next  = 1'b0;
        fault_next = fault_reg;
        rdy_next   = rdy_reg;
        chg_next   = 1'b0;
        msg_next   = msg_reg;
        t_load     = 1'b0;
        t_count    = 32'h0000_0000;
        t_stop     = 1'b0;
        case (state_reg)
            PIS_IDLE: begin
                if (request_ok_in) begin
                    state_next = PIS_SEND_ACCEPT;
                    msg_next   = `PIS_MSG_ACCEPT;
                    fault_next = 1'b0;
                    rdy_next   = 1'b0;
                end
            end
            PIS_SEND_ACCEPT: begin
                if (tx_ready_in) begin
                    state_next = PIS_WAIT_ACK;
                end
            end
            PIS_WAIT_ACK: begin
                if (tx_goodcrc_in) begin
                    state_next = PIS_SETTLE;
                    t_load     = 1'b1;
                    t_count    = SETTLE_CYC;
                end else if (tx_fail_in) begin
                    state_next = PIS_FAULT;
                end
            end
            PIS_SETTLE: begin
                if (t_expired) begin
                    state_next = PIS_SUPPLY_CHANGE;
                    chg_next   = 1'b1;
                    t_load     = 1'b1;
                    t_count    = READY_CYC;
                end
            end
            PIS_SUPPLY_CHANGE: begin
                if (supply_ready_in) begin
                    state_next = PIS_SEND_RDY;
                    t_stop     = 1'b1;
                    rdy_next   = 1'b1;
                    msg_next   = `PIS_MSG_PS_RDY;
                end else if (t_expired) begin
                    state_next = PIS_FAULT;
                end
            end
            PIS_SEND_RDY: begin
                if (tx_ready_in) begin
                    state_next = PIS_WAIT_RDY_ACK;
                end
            end
            PIS_WAIT_RDY_ACK: begin
                if (tx_goodcrc_in) begin
                    state_next = PIS_IDLE;
                    done_next  = 1'b1;
                end else if (tx_fail_in) begin
                    state_next = PIS_FAULT;
                end
            end
            PIS_FAULT: begin
                fault_next = 1'b1;
                state_next = PIS_IDLE;
            end
            default: begin
                state_next = PIS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            state_reg <= PIS_IDLE;
            done_reg  <= 1'b0;
            fault_reg <= 1'b0;
            rdy_reg   <= 1'b0;
            chg_reg   <= 1'b0;
            msg_reg   <= 4'h0;
        end else begin
            state_reg <= state_next;
            done_reg  <= done_next;
            fault_reg <= fault_next;
            rdy_reg   <= rdy_next;
            chg_reg   <= chg_next;
            msg_reg   <= msg_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign tx_valid_out      = (state_reg == PIS_SEND_ACCEPT) || (state_reg == PIS_SEND_RDY);
    assign tx_msg_out        = msg_reg;
    assign supply_change_out = chg_reg;
    assign supply_ready_out  = rdy_reg;
    assign busy_out          = (state_reg != PIS_IDLE);
    assign done_out          = done_reg;
    assign fault_out         = fault_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);

    int settle_cnt_reg;
    int settle_cnt_next;

    // Counts cycles spent in the settle wait
    always_comb begin
        settle_cnt_next = 0;
        if (state_reg == PIS_SETTLE) begin
            settle_cnt_next = settle_cnt_reg + 1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            settle_cnt_reg <= 0;
        end else begin
            settle_cnt_reg <= settle_cnt_next;
        end
    end

    AST_ACCEPT_FIRST: assert property (
        $rose(tx_valid_out) && $past(state_reg == PIS_IDLE) |-> tx_msg_out == `PIS_MSG_ACCEPT)
        else $error("first message is not Accept");
    AST_SETTLE_AFTER_ACK: assert property (
        state_reg == PIS_WAIT_ACK && tx_goodcrc_in |=> state_reg == PIS_SETTLE)
        else $error("settle wait not started on GoodCRC");
    AST_SETTLE_LENGTH: assert property (
        $rose(supply_change_out) |-> $past(settle_cnt_reg) >= int'(SETTLE_CYC))
        else $error("supply commanded before settle wait ended");
    AST_CHANGE_PULSE: assert property (
        supply_change_out |-> state_reg == PIS_SUPPLY_CHANGE ##1 !supply_change_out)
        else $error("supply change not a single pulse");
    AST_READY_TO_PSRDY: assert property (
        state_reg == PIS_SUPPLY_CHANGE && supply_ready_in |=>
        supply_ready_out && tx_valid_out && tx_msg_out == `PIS_MSG_PS_RDY)
        else $error("PS_RDY not sent after supply ready");
    AST_NO_PSRDY_EARLY: assert property (
        tx_valid_out && tx_msg_out == `PIS_MSG_PS_RDY |-> supply_ready_out)
        else $error("PS_RDY sent before supply ready");
    AST_TX_HOLD: assert property (
        tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_msg_out))
        else $error("message dropped before accepted");
    AST_DONE_AFTER_ACK: assert property (
        state_reg == PIS_WAIT_RDY_ACK && tx_goodcrc_in |=> done_out && !busy_out)
        else $error("done not raised after PS_RDY GoodCRC");

    COV_FULL_RUN: cover property (
        state_reg == PIS_SUPPLY_CHANGE && supply_ready_in ##[1:20] done_out);
    COV_READY_TIMEOUT: cover property (
        state_reg == PIS_SUPPLY_CHANGE ##1 state_reg == PIS_FAULT);
    COV_TX_FAIL: cover property (state_reg == PIS_WAIT_ACK && tx_fail_in);
    COV_RDY_FAIL: cover property (state_reg == PIS_WAIT_RDY_ACK && tx_fail_in);
endmodule

// [dv/pis_sink_model.sv]
// Sink port model: protocol layer acknowledge plus sink policy state.
// Assumes the sequencer drives its transmit port on the clk_sys_in rising edge.
`timescale 1ns/10ps
`include "pis_regs.svh"
module pis_sink_model #(
    parameter int TIMER_CYC = 80
) (
    input  wire logic        clk_sys_in,
    input  wire logic        srst_in,
    input  wire logic        tx_valid_in,
    input  pis_pkg::pis_msg_t tx_msg_in,
    input  wire logic [3:0]  lat_in,
    input  wire logic        fail_in,
    output logic             tx_ready_out,
    output logic             tx_goodcrc_out,
    output logic             tx_fail_out,
    output logic             standby_out,
    output logic             permit_out,
    output logic             timeout_err_out
);
    import pis_pkg::*;
    logic     taken = 1'b0;
    logic     run = 1'b0;
    pis_msg_t msg;
    int       wait_cnt = 0;
    int       tmr = 0;
    initial {tx_ready_out, tx_goodcrc_out, tx_fail_out} = 3'h0;
    initial {standby_out, permit_out, timeout_err_out} = 3'h0;
    always @(posedge clk_sys_in) begin
        taken <= tx_valid_in & tx_ready_out;
        msg   <= tx_msg_in;
    end
    // Outputs move on the falling edge, held until the next rising edge samples them
    always @(negedge clk_sys_in) begin
        tx_goodcrc_out <= taken & ~fail_in;
        tx_fail_out    <= taken & fail_in;
        wait_cnt       <= (tx_valid_in && !taken) ? wait_cnt + 1 : 0;
        tx_ready_out   <= tx_valid_in && !taken && !tx_ready_out && wait_cnt >= lat_in;
        tmr            <= (run && !(taken && msg == `PIS_MSG_ACCEPT)) ? tmr + 1 : 0;
        if (srst_in) begin
            {run, standby_out, permit_out, timeout_err_out} <= 4'h0;
        end else if (taken && !fail_in && msg == `PIS_MSG_ACCEPT) begin
            {run, standby_out, permit_out, timeout_err_out} <= 4'hC;
        end else if (taken && !fail_in && msg == `PIS_MSG_PS_RDY) begin
            run         <= 1'b0;
            permit_out  <= 1'b1;
            standby_out <= 1'b0;
        end else if (run && tmr == TIMER_CYC) begin
            run             <= 1'b0;
            timeout_err_out <= 1'b1;
        end
    end
endmodule

// [dv/pis_tb.sv]
// Self-checking bench for the source sequencer against a sink model.
// Assumes short settle and ready counts; inputs move on the falling edge.
`timescale 1ns/10ps
`include "pis_regs.svh"
module testbench;
    import pis_pkg::*;
    localparam int SETTLE = 10;
    localparam int READY  = 50;
    logic       clk_sys_in = 1'b0;
    logic       srst_in = 1'b1;
    logic       request_ok_in = 1'b0;
    logic       supply_ready_in = 1'b0;
    logic       fail_in = 1'b0;
    logic [3:0] lat = 4'h0;
    logic       busy_out, done_out, fault_out, supply_ready_out, tx_valid_out;
    logic       tx_ready_in, tx_goodcrc_in, tx_fail_in, supply_change_out;
    logic       standby, permit, timeout_err;
    pis_msg_t   tx_msg_out;
    int         fail_count = 0;
    int         num_checks = 0;
    always #4 clk_sys_in = ~clk_sys_in;
    pis_source_seq #(.SETTLE_CYC(SETTLE), .READY_CYC(READY)) uut (
        .clk_sys_in(clk_sys_in), .srst_in(srst_in), .request_ok_in(request_ok_in),
        .busy_out(busy_out), .done_out(done_out), .fault_out(fault_out),
        .supply_ready_out(supply_ready_out), .tx_valid_out(tx_valid_out),
        .tx_msg_out(tx_msg_out), .tx_ready_in(tx_ready_in), .tx_goodcrc_in(tx_goodcrc_in),
        .tx_fail_in(tx_fail_in), .supply_change_out(supply_change_out),
        .supply_ready_in(supply_ready_in));
    pis_sink_model sink (
        .clk_sys_in(clk_sys_in), .srst_in(srst_in), .tx_valid_in(tx_valid_out),
        .tx_msg_in(tx_msg_out), .lat_in(lat), .fail_in(fail_in),
        .tx_ready_out(tx_ready_in), .tx_goodcrc_out(tx_goodcrc_in),
        .tx_fail_out(tx_fail_in), .standby_out(standby), .permit_out(permit),
        .timeout_err_out(timeout_err));
    // ****************************************
    // Checking and waiting helpers
    // ****************************************
    task test_done();
        $display("Checks %0d, errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Waits for supply change (0), done (1) or fault (2)
    task wt(input int i, input int lim, output int n);
        n = 0;
        while (n < lim && !(i == 0 ? supply_change_out : i == 1 ? done_out : fault_out)) begin
            @(negedge clk_sys_in);
            n++;
        end
        if (n >= lim) begin
            fail_count++;
            $display("Error at %0t: wait timed out", $time);
            test_done();
        end
    endtask
    task start();
        request_ok_in = 1'b1;
        @(negedge clk_sys_in);
        request_ok_in = 1'b0;
        check(busy_out, 1'b1);
        check(tx_valid_out, 1'b1);
        check(tx_msg_out, `PIS_MSG_ACCEPT);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task run_ok(input logic [3:0] v);
        int n;
        lat = v;
        start();
        check(fault_out, 1'b0);
        wt(0, SETTLE + 40, n);
        check(n >= SETTLE + 2, 1'b1);
        check(standby, 1'b1);
        @(negedge clk_sys_in);
        check(supply_change_out, 1'b0);
        repeat (2) @(negedge clk_sys_in);
        supply_ready_in = 1'b1;
        @(negedge clk_sys_in);
        supply_ready_in = 1'b0;
        check(supply_ready_out, 1'b1);
        check(tx_valid_out, 1'b1);
        check(tx_msg_out, `PIS_MSG_PS_RDY);
        wt(1, 40, n);
        check(busy_out, 1'b0);
        check(permit, 1'b1);
        check(standby, 1'b0);
        check(timeout_err, 1'b0);
        @(negedge clk_sys_in);
        check(done_out, 1'b0);
    endtask
    task t_timeout();
        int n;
        start();
        wt(0, SETTLE + 40, n);
        wt(2, READY + 10, n);
        check(n >= READY - 2, 1'b1);
        check(n <= READY + 4, 1'b1);
        check(supply_ready_out, 1'b0);
        repeat (40) @(negedge clk_sys_in);
        check(timeout_err, 1'b1);
    endtask
    // Transmit failure on Accept (late = 0) or on PS_RDY (late = 1)
    task t_fail(input logic late);
        int n;
        fail_in = !late;
        start();
        if (late) begin
            wt(0, SETTLE + 40, n);
            supply_ready_in = 1'b1;
            fail_in = 1'b1;
            @(negedge clk_sys_in);
            supply_ready_in = 1'b0;
        end
        wt(2, 20, n);
        check(supply_ready_out, late);
        check(permit, 1'b0);
        fail_in = 1'b0;
        repeat (2) @(negedge clk_sys_in);
    endtask
    initial begin
        repeat (2) @(negedge clk_sys_in);
        srst_in = 1'b0;
        run_ok(4'h0);
        run_ok(4'h3);
        t_timeout();
        t_fail(1'b0);
        t_fail(1'b1);
        run_ok(4'h1);
        test_done();
    end
endmodule
